// File: pkg/smcg_map.svh
// What this block does
// [R01] Strap sampled low selects flash run mode, running user code from flash.
// [R02] Strap sampled high selects serial programming mode for flash control.
// [R03] After system or power reset the block is in run mode, core clocked.
// [R04] Deep select clear: wait stops core and random generator clocks only; interrupt ends it.
// [R05] Deep select set: wait stops core, APB, AHB and memory clocks.
// [R06] Wait entered through the event path resumes only on a wakeup event.
// [R07] Exactly two low-power states, sleep and deep sleep; no power-off.
// [R08] Software-enabled option resets the whole system on core lockup.
// [R09] Cause of the most recent reset is held and readable by software.
// [R10] Software may gate unused peripheral clocks.
// [R11] Random generator clock turns off automatically whenever core sleeps.
// [R12] DMA completion raises a wakeup event that ends an event wait.
// [R13] Reset cause survives recorded resets; cleared by power-on or software.
// [R14] Strap sampled once at reset release; mode fixed until next reset.
`ifndef SMCG_MAP_SVH
`define SMCG_MAP_SVH

// ==========================================================
// Register byte offsets
`define SMCG_ADR_CTRL 8'h00
`define SMCG_ADR_STATUS 8'h04
`define SMCG_ADR_CAUSE 8'h08
`define SMCG_ADR_GATE 8'h0c

// ==========================================================
// Field positions
`define SMCG_CTRL_DEEP 0
`define SMCG_CTRL_LOCKUP_EN 1
`define SMCG_STAT_PWR_LO 0
`define SMCG_STAT_PWR_HI 1
`define SMCG_STAT_BY_EVENT 2
`define SMCG_STAT_SERIAL 3
`define SMCG_CAUSE_POWER 0
`define SMCG_CAUSE_PIN 1
`define SMCG_CAUSE_LOCKUP 2

// ==========================================================
// Widths and reset values
`define SMCG_CAUSE_W 3
`define SMCG_GATE_W 8
`define SMCG_GATE_RST 8'hff
`define SMCG_CAUSE_POR 3'h1

`endif

// File: pkg/smcg_pkg.sv
package smcg_pkg;

  // ==========================================================
  // Power states: run plus exactly two low-power states
  typedef enum logic [1:0] {
    SMCG_RUN,
    SMCG_SLEEP,
    SMCG_DEEP
  } smcg_pwr_type;

  // ==========================================================
  // Wishbone request and response
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } smcg_wb_req_type;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } smcg_wb_rsp_type;

  // ==========================================================
  // Clock enables toward the clock generator
  typedef struct packed {
    logic core;
    logic apb;
    logic ahb;
    logic mem;
    logic rng;
  } smcg_clk_en_type;

  // ==========================================================
  // Whole state of the top module
  typedef struct packed {
    smcg_pwr_type pwr;
    logic by_event;
    logic deep_sel;
    logic lockup_en;
    logic [7:0] gate;
    logic strap_done;
    logic serial_mode;
    logic reset_req;
    logic ack;
    logic [31:0] rdat;
  } smcg_top_state_type;

  // Whole state of the reset cause recorder
  typedef struct packed {
    logic [2:0] cause;
    logic pending;
    logic in_rst;
  } smcg_cause_state_type;

endpackage : smcg_pkg

// File: rtl/smcg_cause.sv
`timescale 1ns/1ps
`include "smcg_map.svh"

module smcg_cause (
  // Clock and resets
  input wire logic clk_i,
  input wire logic por_i,
  input wire logic rst_i,
  // Events and software clear
  input wire logic lockup_req_i,
  input wire logic [`SMCG_CAUSE_W-1:0] clr_i,
  // Recorded cause
  output logic [`SMCG_CAUSE_W-1:0] cause_o
);

  smcg_pkg::smcg_cause_state_type s;
  smcg_pkg::smcg_cause_state_type next_s;

  // Only power-on resets this record; system reset only adds its pin or lockup cause bit
  always_comb begin
    next_s = s;
    next_s.in_rst = rst_i;
    next_s.cause = s.cause & ~clr_i; // R13
    if (lockup_req_i) begin
      next_s.pending = 1'b1;
    end else if (s.in_rst && !rst_i) begin
      next_s.pending = 1'b0;
    end
    // Set wins over a software clear in the same cycle
    if (rst_i) begin
      if (s.pending) begin
        next_s.cause[`SMCG_CAUSE_LOCKUP] = 1'b1; // R09
      end else begin
        next_s.cause[`SMCG_CAUSE_PIN] = 1'b1; // R09
      end
    end
  end

  // State register, power-on reset only
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      s <= '{cause: `SMCG_CAUSE_POR, pending: 1'b0, in_rst: 1'b0}; // R13
    end else begin
      s <= next_s;
    end
  end

  assign cause_o = s.cause;

  property p_por_cause;
    @(posedge clk_i) por_i |=> cause_o == `SMCG_CAUSE_POR;
  endproperty
  a_por_cause: assert property (p_por_cause) // R13
    else $error("power-on reset did not leave only the power cause");

  property p_rst_keeps;
    @(posedge clk_i) disable iff (por_i)
      (rst_i && clr_i == '0) |=> ((cause_o & $past(cause_o)) == $past(cause_o));
  endproperty
  a_rst_keeps: assert property (p_rst_keeps) // R13
    else $error("system reset lost a recorded cause");

  property p_lockup_cause;
    @(posedge clk_i) disable iff (por_i)
      (lockup_req_i && !rst_i) ##1 rst_i[*2] |=> cause_o[`SMCG_CAUSE_LOCKUP];
  endproperty
  a_lockup_cause: assert property (p_lockup_cause) // R09
    else $error("lockup reset not recorded");

endmodule : smcg_cause

// File: rtl/smcg_top.sv
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "smcg_map.svh"

module smcg_top (
  // Clock and resets
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  // Wishbone slave
  input wire smcg_pkg::smcg_wb_req_type wb_req_i,
  output smcg_pkg::smcg_wb_rsp_type wb_rsp_o,
  // Core and event inputs
  input wire logic boot_strap_i,
  input wire logic wait_interrupt_entry_i,
  input wire logic wait_event_entry_i,
  input wire logic irq_i,
  input wire logic wake_event_i,
  input wire logic dma_done_i,
  input wire logic core_lockup_i,
  // Clock gating and mode outputs
  output smcg_pkg::smcg_clk_en_type clk_en_o,
  output logic [`SMCG_GATE_W-1:0] periph_clk_en_o,
  output logic flash_run_mode_o,
  output logic serial_programming_mode_o,
  output logic sys_reset_req_o
);

  smcg_pkg::smcg_top_state_type s;
  smcg_pkg::smcg_top_state_type next_s;
  logic [`SMCG_CAUSE_W-1:0] cause;
  logic [`SMCG_CAUSE_W-1:0] cause_clr;
  logic access;
  logic wr_now;
  logic wake;

  // ==========================================================
  // Clock enable decode, used for output and checking
  function automatic smcg_pkg::smcg_clk_en_type clk_dec(
    input smcg_pkg::smcg_pwr_type p
  );
    smcg_pkg::smcg_clk_en_type c;
    c = '1;
    case (p)
      smcg_pkg::SMCG_SLEEP: begin
        c.core = 1'b0; // R04
        c.rng = 1'b0; // R11
      end
      smcg_pkg::SMCG_DEEP: begin
        c = '0; // R05
      end
      default: begin
        c = '1;
      end
    endcase
    return c;
  endfunction : clk_dec

  // Register read mux
  function automatic logic [31:0] rd_mux(
    input logic [7:0] a,
    input smcg_pkg::smcg_top_state_type st,
    input logic [`SMCG_CAUSE_W-1:0] cs
  );
    logic [31:0] d;
    d = '0;
    case (a)
      `SMCG_ADR_CTRL: begin
        d[`SMCG_CTRL_DEEP] = st.deep_sel;
        d[`SMCG_CTRL_LOCKUP_EN] = st.lockup_en;
      end
      `SMCG_ADR_STATUS: begin
        d[`SMCG_STAT_PWR_HI:`SMCG_STAT_PWR_LO] = st.pwr;
        d[`SMCG_STAT_BY_EVENT] = st.by_event;
        d[`SMCG_STAT_SERIAL] = st.serial_mode;
      end
      `SMCG_ADR_CAUSE: begin
        d[`SMCG_CAUSE_W-1:0] = cs; // R09
      end
      `SMCG_ADR_GATE: begin
        d[`SMCG_GATE_W-1:0] = st.gate;
      end
      default: begin
        d = '0;
      end
    endcase
    return d;
  endfunction : rd_mux

  // ==========================================================
  // Bus decode: ack one cycle after request, write at the acked edge
  assign access = wb_req_i.cyc && wb_req_i.stb;
  assign wr_now = access && wb_req_i.we && s.ack;
  assign cause_clr = (wr_now && wb_req_i.sel[0] &&
                      wb_req_i.adr == `SMCG_ADR_CAUSE) ?
                     wb_req_i.dat[`SMCG_CAUSE_W-1:0] : '0;

  // Wake condition depends on how the wait was entered
  assign wake = s.by_event ? (wake_event_i || dma_done_i) : irq_i; // R06 R12

  // ==========================================================
  // Next state
  always_comb begin
    next_s = s;
    next_s.ack = access && !s.ack;
    if (access && !s.ack) begin
      next_s.rdat = rd_mux(wb_req_i.adr, s, cause);
    end
    // Register writes
    if (wr_now && wb_req_i.sel[0]) begin
      if (wb_req_i.adr == `SMCG_ADR_CTRL) begin
        next_s.deep_sel = wb_req_i.dat[`SMCG_CTRL_DEEP];
        next_s.lockup_en = wb_req_i.dat[`SMCG_CTRL_LOCKUP_EN];
      end
      if (wb_req_i.adr == `SMCG_ADR_GATE) begin
        next_s.gate = wb_req_i.dat[`SMCG_GATE_W-1:0]; // R10
      end
    end
    // Strap captured once, the first cycle after reset release
    if (!s.strap_done) begin
      next_s.strap_done = 1'b1; // R14
      next_s.serial_mode = boot_strap_i; // R01 R02
    end
    // Lockup reset request held until the system reset arrives
    if (core_lockup_i && s.lockup_en) begin
      next_s.reset_req = 1'b1; // R08
    end
    // Power state machine
    case (s.pwr)
      smcg_pkg::SMCG_RUN: begin
        if (wait_event_entry_i) begin
          next_s.by_event = 1'b1;
          next_s.pwr = s.deep_sel ? smcg_pkg::SMCG_DEEP
                                  : smcg_pkg::SMCG_SLEEP; // R07
        end else if (wait_interrupt_entry_i && !irq_i) begin
          next_s.by_event = 1'b0;
          next_s.pwr = s.deep_sel ? smcg_pkg::SMCG_DEEP
                                  : smcg_pkg::SMCG_SLEEP; // R04 R05
        end
      end
      smcg_pkg::SMCG_SLEEP, smcg_pkg::SMCG_DEEP: begin
        if (wake) begin
          next_s.pwr = smcg_pkg::SMCG_RUN; // R04 R06
          next_s.by_event = 1'b0;
        end
      end
      default: begin
        next_s.pwr = smcg_pkg::SMCG_RUN;
      end
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '{pwr: smcg_pkg::SMCG_RUN, by_event: 1'b0, deep_sel: 1'b0,
             lockup_en: 1'b0, gate: `SMCG_GATE_RST, strap_done: 1'b0,
             serial_mode: 1'b0, reset_req: 1'b0, ack: 1'b0,
             rdat: '0}; // R03
    end else begin
      s <= next_s;
    end
  end

  // Reset cause recorder
  smcg_cause u_cause (
    .clk_i(clk_i),
    .por_i(por_i),
    .rst_i(rst_i),
    .lockup_req_i(s.reset_req),
    .clr_i(cause_clr),
    .cause_o(cause)
  );

  // ==========================================================
  // Outputs
  assign wb_rsp_o.ack = s.ack;
  assign wb_rsp_o.dat = s.rdat;
  assign clk_en_o = clk_dec(s.pwr);
  assign periph_clk_en_o = s.gate & {`SMCG_GATE_W{clk_en_o.apb}}; // R10
  assign serial_programming_mode_o = s.serial_mode; // R02
  assign flash_run_mode_o = !s.serial_mode; // R01
  assign sys_reset_req_o = s.reset_req;

  // ==========================================================
  // Checks
  property p_reset_run;
    @(posedge clk_i) $fell(rst_i) |-> clk_en_o == '1;
  endproperty
  a_reset_run: assert property (p_reset_run) // R03
    else $error("not in run mode after reset");

  property p_sleep_clocks;
    @(posedge clk_i) disable iff (rst_i)
      (s.pwr == smcg_pkg::SMCG_RUN && wait_event_entry_i && !s.deep_sel)
      |=> (!clk_en_o.core && clk_en_o.apb && clk_en_o.ahb && clk_en_o.mem);
  endproperty
  a_sleep_clocks: assert property (p_sleep_clocks) // R04
    else $error("sleep gated the wrong clocks");

  property p_deep_clocks;
    @(posedge clk_i) disable iff (rst_i)
      (s.pwr == smcg_pkg::SMCG_RUN && wait_interrupt_entry_i && !irq_i &&
       s.deep_sel) |=> (clk_en_o == '0 && periph_clk_en_o == '0);
  endproperty
  a_deep_clocks: assert property (p_deep_clocks) // R05
    else $error("deep sleep left a clock running");

  property p_irq_wakes;
    @(posedge clk_i) disable iff (rst_i)
      (!clk_en_o.core && !s.by_event && irq_i) |=> clk_en_o.core;
  endproperty
  a_irq_wakes: assert property (p_irq_wakes) // R04
    else $error("interrupt did not end an interrupt wait");

  property p_event_only;
    @(posedge clk_i) disable iff (rst_i)
      (!clk_en_o.core && s.by_event && !wake_event_i && !dma_done_i)
      |=> !clk_en_o.core;
  endproperty
  a_event_only: assert property (p_event_only) // R06
    else $error("event wait ended without a wakeup event");

  property p_dma_wakes;
    @(posedge clk_i) disable iff (rst_i)
      (!clk_en_o.core && s.by_event && dma_done_i) |=> clk_en_o.core;
  endproperty
  a_dma_wakes: assert property (p_dma_wakes) // R12
    else $error("DMA completion did not wake the core");

  property p_rng_off;
    @(posedge clk_i) disable iff (rst_i) !clk_en_o.core |-> !clk_en_o.rng;
  endproperty
  a_rng_off: assert property (p_rng_off) // R11
    else $error("random generator clock running while asleep");

  property p_two_states;
    @(posedge clk_i) disable iff (rst_i)
      !clk_en_o.core |-> (clk_en_o.apb == (s.pwr == smcg_pkg::SMCG_SLEEP));
  endproperty
  a_two_states: assert property (p_two_states) // R07
    else $error("low-power state is neither sleep nor deep sleep");

  property p_lockup_req;
    @(posedge clk_i) disable iff (rst_i)
      (core_lockup_i && s.lockup_en) |=> sys_reset_req_o;
  endproperty
  a_lockup_req: assert property (p_lockup_req) // R08
    else $error("lockup did not request a system reset");

  property p_strap;
    @(posedge clk_i) disable iff (rst_i)
      !s.strap_done |=> serial_programming_mode_o == $past(boot_strap_i);
  endproperty
  a_strap: assert property (p_strap) // R01
    else $error("startup mode does not follow the strap");

  property p_mode_fixed;
    @(posedge clk_i) disable iff (rst_i)
      s.strap_done |=> $stable(serial_programming_mode_o);
  endproperty
  a_mode_fixed: assert property (p_mode_fixed) // R14
    else $error("startup mode changed after capture");

endmodule : smcg_top

// File: tb/smcg_core_model.sv
`timescale 1ns/1ps

module smcg_core_model (
  // Clock
  input wire logic clk_i,
  // Core side toward the controller
  output logic wait_interrupt_entry_o,
  output logic wait_event_entry_o,
  output logic core_lockup_o,
  output logic boot_strap_o
);
  // ==========================================================
  // Quiet core at time zero, strap low
  initial begin
    wait_interrupt_entry_o = 1'b0;
    wait_event_entry_o = 1'b0;
    core_lockup_o = 1'b0;
    boot_strap_o = 1'b0;
  end

  // One-cycle wait instruction, either kind
  task automatic issue(input logic by_event);
    @(posedge clk_i);
    wait_interrupt_entry_o <= !by_event;
    wait_event_entry_o <= by_event;
    @(posedge clk_i);
    wait_interrupt_entry_o <= 1'b0;
    wait_event_entry_o <= 1'b0;
  endtask : issue

  // Strap and lockup are levels held by the board and core
  task automatic set_pins(input logic strap, input logic lockup);
    @(posedge clk_i);
    boot_strap_o <= strap;
    core_lockup_o <= lockup;
  endtask : set_pins
endmodule : smcg_core_model

// File: tb/tb_smcg_top.sv
`timescale 1ns/1ps
`include "smcg_map.svh"

module tb_smcg_top;
  // ==========================================================
  // One power scenario: entry kind, depth, expected outputs
  typedef struct packed {
    logic by_evt;
    logic deep;
    logic dma;
    logic [4:0] en;
    logic [7:0] per;
    logic [31:0] stat;
  } smcg_row_type;

  localparam int LIMIT = 3000;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic por_i = 1'b1;
  logic irq_i = 1'b0;
  logic wake_event_i = 1'b0;
  logic dma_done_i = 1'b0;
  logic wait_int;
  logic wait_evt;
  logic lockup;
  logic strap;
  logic sys_reset_req_o;
  logic flash_run_mode_o;
  logic serial_programming_mode_o;
  logic [7:0] periph_clk_en_o;
  smcg_pkg::smcg_wb_req_type req = '0;
  smcg_pkg::smcg_wb_rsp_type wb_rsp_o;
  smcg_pkg::smcg_clk_en_type clk_en_o;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] q;
  smcg_row_type rows [4] = '{
    '{1'b0, 1'b0, 1'b0, 5'h0e, 8'hff, 32'h1},
    '{1'b0, 1'b1, 1'b0, 5'h00, 8'h00, 32'h2},
    '{1'b1, 1'b0, 1'b0, 5'h0e, 8'hff, 32'h5},
    '{1'b1, 1'b1, 1'b1, 5'h00, 8'h00, 32'h6}};

  // ==========================================================
  // Clock and cycle ceiling
  always #5 clk_i = !clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      end_sim();
    end
  end

  // ==========================================================
  // Design and core model
  smcg_top uut (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i),
    .wb_req_i(req), .wb_rsp_o(wb_rsp_o), .boot_strap_i(strap),
    .wait_interrupt_entry_i(wait_int), .wait_event_entry_i(wait_evt),
    .irq_i(irq_i), .wake_event_i(wake_event_i), .dma_done_i(dma_done_i),
    .core_lockup_i(lockup), .clk_en_o(clk_en_o),
    .periph_clk_en_o(periph_clk_en_o), .flash_run_mode_o(flash_run_mode_o),
    .serial_programming_mode_o(serial_programming_mode_o),
    .sys_reset_req_o(sys_reset_req_o));
  smcg_core_model core (.clk_i(clk_i), .wait_interrupt_entry_o(wait_int),
    .wait_event_entry_o(wait_evt), .core_lockup_o(lockup),
    .boot_strap_o(strap));

  // ==========================================================
  // Comparison, closing report, bus cycle, reset pulse
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  task automatic wb(input logic we, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a, dat: d};
    do @(posedge clk_i); while (wb_rsp_o.ack !== 1'b1);
    q = wb_rsp_o.dat;
    req <= '0;
  endtask : wb

  task automatic sys_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
  endtask : sys_reset

  // ==========================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    check("flash mode", flash_run_mode_o, 32'h1);
    check("clock enables", clk_en_o, 32'h1f);
    wb(1'h0, `SMCG_ADR_CAUSE, 32'h0);
    check("cause after power-on", q, 32'h1);
    // Table of wait entries and their wakeups
    foreach (rows[i]) begin
      wb(1'h1, `SMCG_ADR_CTRL, {31'h0, rows[i].deep});
      core.issue(rows[i].by_evt);
      @(posedge clk_i);
      #1;
      check("gated enables", clk_en_o, rows[i].en);
      check("peripheral enables", periph_clk_en_o, rows[i].per);
      wb(1'h0, `SMCG_ADR_STATUS, 32'h0);
      check("status asleep", q, rows[i].stat);
      // The other kind of wakeup must leave the wait alone
      irq_i <= rows[i].by_evt;
      wake_event_i <= !rows[i].by_evt;
      repeat (3) @(posedge clk_i);
      irq_i <= !rows[i].by_evt;
      wake_event_i <= rows[i].by_evt && !rows[i].dma;
      dma_done_i <= rows[i].dma;
      #1;
      check("wrong wake kept asleep", clk_en_o, rows[i].en);
      @(posedge clk_i);
      irq_i <= 1'h0;
      wake_event_i <= 1'h0;
      dma_done_i <= 1'h0;
      #1;
      check("woken enables", clk_en_o, 32'h1f);
    end
    // Interrupt wait with an interrupt already pending is ignored
    @(posedge clk_i);
    irq_i <= 1'h1;
    core.issue(1'h0);
    #1;
    check("pending interrupt", clk_en_o, 32'h1f);
    @(posedge clk_i);
    irq_i <= 1'h0;
    // Peripheral gating, read-only status, unmapped place
    wb(1'h1, `SMCG_ADR_GATE, 32'h5a);
    wb(1'h0, `SMCG_ADR_GATE, 32'h0);
    check("gate readback", q, 32'h5a);
    check("gated peripherals", periph_clk_en_o, 32'h5a);
    wb(1'h1, `SMCG_ADR_STATUS, 32'h7);
    wb(1'h0, `SMCG_ADR_STATUS, 32'h0);
    check("status read only", q, 32'h0);
    wb(1'h0, 8'h10, 32'h0);
    check("unmapped read", q, 32'h0);
    // Lockup reset, disabled then enabled
    wb(1'h1, `SMCG_ADR_CTRL, 32'h0);
    core.set_pins(1'h1, 1'h1);
    repeat (3) @(posedge clk_i);
    #1;
    check("lockup disabled", sys_reset_req_o, 32'h0);
    wb(1'h1, `SMCG_ADR_CTRL, 32'h2);
    repeat (2) @(posedge clk_i);
    #1;
    check("lockup reset request", sys_reset_req_o, 32'h1);
    core.set_pins(1'h1, 1'h0);
    sys_reset();
    check("request cleared", sys_reset_req_o, 32'h0);
    check("serial mode", serial_programming_mode_o, 32'h1);
    check("flash mode off", flash_run_mode_o, 32'h0);
    wb(1'h0, `SMCG_ADR_CAUSE, 32'h0);
    check("cause after lockup", q, 32'h5);
    core.set_pins(1'h0, 1'h0);
    repeat (3) @(posedge clk_i);
    #1;
    check("mode held", serial_programming_mode_o, 32'h1);
    sys_reset();
    check("flash mode again", flash_run_mode_o, 32'h1);
    wb(1'h0, `SMCG_ADR_CAUSE, 32'h0);
    check("cause after pin reset", q, 32'h7);
    wb(1'h1, `SMCG_ADR_CAUSE, 32'h7);
    wb(1'h0, `SMCG_ADR_CAUSE, 32'h0);
    check("cause cleared", q, 32'h0);
    end_sim();
  end
endmodule : tb_smcg_top
